// file: core/tks_pkg.sv
// Constants and carrier types for the touch-key status command responder
package tks_pkg;

    // ------------------------------------------------------------------
    // Key matrix sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_KEYS  = 48;
    localparam int unsigned MAP_BYTES = 6;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_STATUS  = 8'h05;
    localparam logic [7:0] CMD_FIRST   = 8'h06;
    localparam logic [7:0] CMD_DETECT  = 8'h07;
    localparam logic [7:0] CMD_SIGNAL  = 8'h08;
    localparam logic [7:0] CMD_REFS    = 8'h09;
    localparam logic [7:0] CMD_DELTA   = 8'h0A;
    localparam logic [7:0] CMD_ERRMAP  = 8'h0B;
    localparam logic [7:0] CMD_LINE    = 8'h0C;
    localparam logic [7:0] CMD_DUMP    = 8'h0D;
    localparam logic [7:0] CMD_EECRC   = 8'h0E;
    localparam logic [7:0] CMD_LAST    = 8'h0F;
    localparam logic [7:0] CMD_CODE1   = 8'h10;
    localparam logic [7:0] CMD_CODE3   = 8'h11;

    // ------------------------------------------------------------------
    // Response field values and lengths
    // ------------------------------------------------------------------
    localparam logic [5:0] FIRST_NONE     = 6'h3F;
    localparam logic [7:0] LINE_Y_ALL     = 8'hFF;
    localparam logic [7:0] DELTA_MAX      = 8'hFF;
    localparam logic [2:0] CAL_FAIL_TRIES = 3'h5;
    localparam logic [9:0] LEN_WORDS      = 10'h060;
    localparam logic [9:0] LEN_KEYS       = 10'h030;
    localparam logic [9:0] LEN_MAP        = 10'h006;
    localparam logic [9:0] LEN_CODE3      = 10'h003;
    localparam logic [9:0] LEN_ONE        = 10'h001;
    localparam logic [9:0] LEN_CRC16      = 10'h002;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLOCK_HZ      = 64'd40_000_000;
    localparam longint unsigned GAP_LIMIT_MS  = 64'd100;
    localparam longint unsigned SYNC_LIMIT_MS = 64'd100;
    localparam int unsigned GAP_LIMIT_CYC  =
        32'(GAP_LIMIT_MS * CLOCK_HZ / 64'd1000);
    localparam int unsigned SYNC_LIMIT_CYC =
        32'(SYNC_LIMIT_MS * CLOCK_HZ / 64'd1000);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } tks_rx_t;

    typedef struct packed {
        logic [NUM_KEYS-1:0] detect;
        logic [NUM_KEYS-1:0] calib;
        logic [NUM_KEYS-1:0] enabled;
    } tks_keys_t;

endpackage : tks_pkg

// file: core/tks_responder.sv
// Status and report command responder of the touch-key controller
//
// Operation
// - Status byte: link, line, store, sync, cal, activity
// - Link failure flag set by comm failure
// - No sync pulse in 100 ms flags error
// - Five failed cals or low signal flags
// - CRC byte seeded by command, then response
// - First-key byte: key number, error, multiple
// - No key touched gives 0x3F number
// - Six-byte detection map, key n bit n
// - Signals and references: 48 words, low first
// - Deltas: reference minus signal, clamped 0..255
// - Error map: low signal or calibrating keys
// - Calibrating error bit clears with calibration
// - Line byte: X faults, Y fault gives 0xFF
// - Setups dump aborts on 100 ms gap
// - Sensing held during setups dump
// - Dump ends with stored 16-bit CRC
// - Stored-data CRC returned low first, no CRC
// - Last-command query returns inverted previous byte
// - Last-command query clears link failure flag
// - Internal code byte plus CRC
// - Three-byte diagnostic word plus CRC
// - Byte gap over 100 ms abandons command
// - Response starts within 1 ms; stored-data CRC waits for store CRC ready
// - Multi-byte values sent low byte first
`timescale 1ns/1ps

module tks_responder #(
    parameter int unsigned SETUP_LEN   = 256,
    parameter int unsigned GAP_CYCLES  = tks_pkg::GAP_LIMIT_CYC,
    parameter int unsigned SYNC_CYCLES = tks_pkg::SYNC_LIMIT_CYC,
    parameter logic [7:0]  CRC8_POLY   = 8'h07,
    parameter logic [7:0]  CRC8_INIT   = 8'h00,
    parameter int unsigned ADDR_W      = $clog2(SETUP_LEN)
) (
    input  wire logic              clock,          // 40 MHz clock
    input  wire logic              sys_rst,        // Sync reset, high
    input  wire tks_pkg::tks_rx_t  rxIn,           // Received byte/failure
    input  wire logic              txReady,        // Link takes tx byte
    output logic                   txValid,        // Tx byte offered
    output logic [7:0]             txByte,         // Tx byte
    input  wire tks_pkg::tks_keys_t keys,          // Live key state
    input  wire logic [47:0]       keyCalEnd,      // Cal attempt ended
    input  wire logic [47:0]       keyCalPass,     // Cal attempt passed
    input  wire logic [767:0]      keySignals,     // 16-bit signals
    input  wire logic [767:0]      keyRefs,        // 16-bit references
    input  wire logic [15:0]       lowSignalLimit, // Low signal limit
    input  wire logic [7:0]        xLineFault,     // X line faults
    input  wire logic              yLineFault,     // Any Y line fault
    input  wire logic              setupsCorrupt,  // Stored setups bad
    input  wire logic              syncPin,        // Mains sync pin
    output logic [ADDR_W-1:0]      setupRdAddr,    // Setups read index
    input  wire logic [7:0]        setupRdData,    // Setups byte
    input  wire logic [15:0]       setupCrc,       // Stored setups CRC
    output logic                   storeCrcReq,    // Start store CRC
    input  wire logic              storeCrcDone,   // Store CRC ready
    input  wire logic [15:0]       storeCrcValue,  // Store CRC value
    input  wire logic [7:0]        codeByte,       // Internal code
    input  wire logic [23:0]       codeWord,       // Diagnostic word
    output logic                   senseHold,      // Suspend sensing
    output logic                   slowScan,       // Reduced scan rate
    output logic                   linkFail        // Link failure flag
);

    typedef enum {StIdle, StStoreWait, StSend} tks_state_t;

    tks_state_t  state_q;
    logic [7:0]  cmd_q;
    logic [7:0]  lastCmd_q;
    logic [7:0]  echo_q;
    logic [9:0]  idx_q;
    logic [7:0]  crc_q;
    logic [15:0] storeCrc_q;
    logic        txValid_q;
    logic [7:0]  txByte_q;
    logic        storeCrcReq_q;
    logic        senseHold_q;
    logic        slowScan_q;
    logic        linkFail_q;
    logic        syncErr_q;
    logic        syncMeta_q;
    logic        syncSafe_q;
    logic        syncPrev_q;
    logic [31:0] syncCnt_q;
    logic [31:0] gapCnt_q;
    logic [47:0] calFail_q;
    logic [47:0] lowSig;
    logic [47:0] errMap;
    logic [5:0]  firstKey;
    logic [7:0]  statusByte;
    logic [7:0]  firstByte;
    logic [7:0]  lineByte;
    logic [7:0]  payload;
    logic [7:0]  nextByte;
    logic [9:0]  dataLen;
    logic [9:0]  totalLen;
    logic [15:0] wordVal;
    logic [15:0] crc16Val;
    logic [16:0] deltaDiff;
    logic        take;
    logic        loadNow;
    logic        finish;
    logic        stall;
    logic        gapOut;
    logic        syncEdge;
    logic        syncOut;

    // ------------------------------------------------------------------
    // CRC step
    // ------------------------------------------------------------------
    function automatic logic [7:0] crc8Step(input logic [7:0] crc,
                                            input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int b = 0; b < 8; b++) begin
            c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
        end
        return c;
    endfunction : crc8Step

    // ------------------------------------------------------------------
    // Per-key condition flags
    // ------------------------------------------------------------------
    for (genvar k = 0; k < 48; k++) begin : g_key
        logic [2:0] tries_q;
        assign lowSig[k] = keys.enabled[k]
                         && keyRefs[k*16 +: 16] < lowSignalLimit;
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                tries_q      <= 3'h0;
                calFail_q[k] <= 1'b0;
            end else if (keyCalEnd[k]) begin
                if (keyCalPass[k]) begin
                    tries_q      <= 3'h0;
                    calFail_q[k] <= 1'b0;
                end else if (tries_q == tks_pkg::CAL_FAIL_TRIES - 3'h1) begin
                    tries_q      <= tks_pkg::CAL_FAIL_TRIES;
                    calFail_q[k] <= 1'b1;
                end else if (tries_q < tks_pkg::CAL_FAIL_TRIES) begin
                    tries_q <= tries_q + 3'h1;
                end
            end
        end
    end

    // Calibrating keys read live, so their bits clear on their own
    assign errMap = keys.calib | lowSig;

    // ------------------------------------------------------------------
    // Response fields
    // ------------------------------------------------------------------
    always_comb begin
        firstKey = tks_pkg::FIRST_NONE;
        for (int k = 47; k >= 0; k--) begin
            if (keys.detect[k]) begin
                firstKey = 6'(k);
            end
        end
    end

    assign lineByte   = yLineFault ? tks_pkg::LINE_Y_ALL : xLineFault;
    assign statusByte = {1'b0, linkFail_q, |lineByte, setupsCorrupt,
                         syncErr_q,
                         |(calFail_q & keys.enabled) | (|lowSig),
                         |keys.calib, |keys.detect};
    assign firstByte  = {|(keys.detect & (keys.detect - 48'h1)),
                         |statusByte[6:2] | (|errMap), firstKey};

    assign wordVal   = (cmd_q == tks_pkg::CMD_SIGNAL)
                     ? keySignals[{idx_q[6:1], 4'h0} +: 16]
                     : keyRefs[{idx_q[6:1], 4'h0} +: 16];
    assign deltaDiff = {1'b0, keyRefs[{idx_q[5:0], 4'h0} +: 16]}
                     - {1'b0, keySignals[{idx_q[5:0], 4'h0} +: 16]};
    assign crc16Val  = (cmd_q == tks_pkg::CMD_DUMP) ? setupCrc : storeCrc_q;

    always_comb begin
        payload  = 8'h00;
        dataLen  = 10'h000;
        totalLen = 10'h000;
        case (cmd_q)
            tks_pkg::CMD_STATUS: begin
                payload = statusByte;
                dataLen = tks_pkg::LEN_ONE;
            end
            tks_pkg::CMD_FIRST: begin
                payload = firstByte;
                dataLen = tks_pkg::LEN_ONE;
            end
            tks_pkg::CMD_DETECT: begin
                payload = keys.detect[{idx_q[2:0], 3'h0} +: 8];
                dataLen = tks_pkg::LEN_MAP;
            end
            tks_pkg::CMD_ERRMAP: begin
                payload = errMap[{idx_q[2:0], 3'h0} +: 8];
                dataLen = tks_pkg::LEN_MAP;
            end
            tks_pkg::CMD_LINE: begin
                payload = lineByte;
                dataLen = tks_pkg::LEN_ONE;
            end
            tks_pkg::CMD_CODE1: begin
                payload = codeByte;
                dataLen = tks_pkg::LEN_ONE;
            end
            tks_pkg::CMD_CODE3: begin
                payload = codeWord[{idx_q[1:0], 3'h0} +: 8];
                dataLen = tks_pkg::LEN_CODE3;
            end
            tks_pkg::CMD_SIGNAL, tks_pkg::CMD_REFS: begin
                payload  = idx_q[0] ? wordVal[15:8] : wordVal[7:0];
                dataLen  = tks_pkg::LEN_WORDS;
                totalLen = tks_pkg::LEN_WORDS;
            end
            tks_pkg::CMD_DELTA: begin
                if (deltaDiff[16]) begin
                    payload = 8'h00;
                end else if (deltaDiff[15:8] != 8'h00) begin
                    payload = tks_pkg::DELTA_MAX;
                end else begin
                    payload = deltaDiff[7:0];
                end
                dataLen  = tks_pkg::LEN_KEYS;
                totalLen = tks_pkg::LEN_KEYS;
            end
            tks_pkg::CMD_DUMP: begin
                payload  = setupRdData;
                dataLen  = 10'(SETUP_LEN);
                totalLen = 10'(SETUP_LEN) + tks_pkg::LEN_CRC16;
            end
            tks_pkg::CMD_EECRC: begin
                totalLen = tks_pkg::LEN_CRC16;
            end
            tks_pkg::CMD_LAST: begin
                payload  = echo_q;
                dataLen  = tks_pkg::LEN_ONE;
                totalLen = tks_pkg::LEN_ONE;
            end
            default: begin
                payload = 8'h00;
            end
        endcase
        if (totalLen == 10'h000 && dataLen != 10'h000) begin
            totalLen = dataLen + tks_pkg::LEN_ONE;
        end
    end

    always_comb begin
        if (idx_q < dataLen) begin
            nextByte = payload;
        end else if (cmd_q == tks_pkg::CMD_DUMP
                  || cmd_q == tks_pkg::CMD_EECRC) begin
            nextByte = (idx_q == dataLen) ? crc16Val[7:0]
                                          : crc16Val[15:8];
        end else begin
            nextByte = crc_q;
        end
    end

    // ------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------
    assign take    = state_q == StIdle && rxIn.valid;
    assign stall   = txValid_q && !txReady;
    assign loadNow = state_q == StSend && !stall && idx_q < totalLen;
    assign finish  = state_q == StSend && !stall && idx_q >= totalLen;
    assign gapOut  = stall && gapCnt_q >= GAP_CYCLES - 32'h1;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= StIdle;
        end else begin
            case (state_q)
                StIdle: begin
                    if (take) begin
                        state_q <= (rxIn.data == tks_pkg::CMD_EECRC)
                                 ? StStoreWait : StSend;
                    end
                end
                StStoreWait: begin
                    if (storeCrcDone) begin
                        state_q <= StSend;
                    end
                end
                StSend: begin
                    if (finish || gapOut) begin
                        state_q <= StIdle;
                    end
                end
                default: begin
                    state_q <= StIdle;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_q  <= 8'h00;
            echo_q <= 8'h00;
            crc_q  <= 8'h00;
        end else if (take) begin
            cmd_q  <= rxIn.data;
            echo_q <= ~lastCmd_q;
            crc_q  <= crc8Step(CRC8_INIT, rxIn.data);
        end else if (loadNow && idx_q < dataLen) begin
            crc_q <= crc8Step(crc_q, payload);
        end
    end

    // Every received byte is remembered, even ones not executed
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lastCmd_q <= 8'h00;
        end else if (rxIn.valid) begin
            lastCmd_q <= rxIn.data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || take) begin
            idx_q <= 10'h000;
        end else if (loadNow) begin
            idx_q <= idx_q + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txValid_q <= 1'b0;
            txByte_q  <= 8'h00;
        end else if (gapOut) begin
            txValid_q <= 1'b0;
        end else if (loadNow) begin
            txValid_q <= 1'b1;
            txByte_q  <= nextByte;
        end else if (txReady) begin
            txValid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !stall) begin
            gapCnt_q <= 32'h0;
        end else begin
            gapCnt_q <= gapCnt_q + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            storeCrcReq_q <= 1'b0;
            storeCrc_q    <= 16'h0000;
        end else begin
            storeCrcReq_q <= take && rxIn.data == tks_pkg::CMD_EECRC;
            if (state_q == StStoreWait && storeCrcDone) begin
                storeCrc_q <= storeCrcValue;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            senseHold_q <= 1'b0;
        end else begin
            senseHold_q <= state_q == StSend
                        && cmd_q == tks_pkg::CMD_DUMP;
        end
    end

    // Failure wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            linkFail_q <= 1'b0;
        end else if (rxIn.err) begin
            linkFail_q <= 1'b1;
        end else if (take && rxIn.data == tks_pkg::CMD_LAST) begin
            linkFail_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mains sync watch
    // ------------------------------------------------------------------
    assign syncEdge = syncSafe_q && !syncPrev_q;
    assign syncOut  = !syncEdge && syncCnt_q >= SYNC_CYCLES - 32'h1;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncMeta_q <= 1'b0;
            syncSafe_q <= 1'b0;
            syncPrev_q <= 1'b0;
        end else begin
            syncMeta_q <= syncPin;
            syncSafe_q <= syncMeta_q;
            syncPrev_q <= syncSafe_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || syncEdge || syncOut) begin
            syncCnt_q <= 32'h0;
        end else begin
            syncCnt_q <= syncCnt_q + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncErr_q  <= 1'b0;
            slowScan_q <= 1'b0;
        end else begin
            if (syncOut) begin
                syncErr_q <= 1'b1;
            end else if (syncEdge) begin
                syncErr_q <= 1'b0;
            end
            slowScan_q <= syncErr_q;
        end
    end

    assign txValid     = txValid_q;
    assign txByte      = txByte_q;
    assign setupRdAddr = idx_q[ADDR_W-1:0];
    assign storeCrcReq = storeCrcReq_q;
    assign senseHold   = senseHold_q;
    assign slowScan    = slowScan_q;
    assign linkFail    = linkFail_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence sTake(logic [7:0] c);
        take && rxIn.data == c;
    endsequence

    a_link_set: assert property (rxIn.err |=> linkFail_q)
        else $error("link failure not flagged");
    a_link_clear: assert property (take && !rxIn.err
        && rxIn.data == tks_pkg::CMD_LAST |=> !linkFail_q)
        else $error("link failure not cleared by last-command query");
    a_last_echo: assert property (sTake(tks_pkg::CMD_LAST)
        |-> ##2 txValid_q && txByte_q == ~$past(lastCmd_q, 2))
        else $error("last-command echo wrong");
    a_status_byte: assert property (sTake(tks_pkg::CMD_STATUS)
        ##1 !rxIn.err |-> ##1 !txByte_q[7]
        && txByte_q[6] == $past(linkFail_q))
        else $error("status byte bits wrong");
    a_first_none: assert property (loadNow && idx_q == 10'h000
        && cmd_q == tks_pkg::CMD_FIRST && keys.detect == 48'h0
        |=> txByte_q[5:0] == tks_pkg::FIRST_NONE)
        else $error("no-key code not 0x3F");
    a_resp_start: assert property (take ##1 (totalLen != 10'h000
        && cmd_q != tks_pkg::CMD_EECRC) |-> ##[1:3] txValid_q)
        else $error("response late");
    a_gap_abort: assert property (gapOut |=> state_q == StIdle
        && !txValid_q)
        else $error("stalled transfer not abandoned");
    a_sense_hold: assert property (state_q == StSend
        && cmd_q == tks_pkg::CMD_DUMP |=> senseHold_q)
        else $error("sensing not held during dump");
    a_sync_error: assert property (syncOut |=> syncErr_q ##1 slowScan_q)
        else $error("sync loss not flagged");

endmodule : tks_responder

// file: dv/tks_host_model.sv
// Host-side link model that accepts response bytes, fast or slow
`timescale 1ns/1ps

module tks_host_model (
    input  wire logic clock,  // Bench clock
    input  wire logic slow,   // Accept on alternate cycles only
    input  wire logic stop,   // Refuse every byte
    output logic      txReady // Host accepts the offered byte
);
    // Ready moves just after an edge, so each byte is taken whole
    always_ff @(posedge clock) begin
        txReady <= stop ? 1'h0 : slow ? (txReady !== 1'h1) : 1'h1;
    end
endmodule : tks_host_model

// file: dv/tks_responder_test.sv
// Self-checking bench for the touch-key status command responder
`timescale 1ns/1ps

module tks_responder_test;
    logic              clock;
    logic              sys_rst;
    tks_pkg::tks_rx_t  rxIn;
    tks_pkg::tks_keys_t keys;
    logic              txReady;
    logic              txValid;
    logic [7:0]        txByte;
    logic [47:0]       keyCalEnd;
    logic [767:0]      keySignals;
    logic [767:0]      keyRefs;
    logic [7:0]        xLineFault;
    logic              yLineFault;
    logic              syncPin;
    logic [3:0]        rdAddr;
    logic [7:0]        codeByte;
    logic [23:0]       codeWord;
    logic              slowScan;
    logic              linkFail;
    logic              slow;
    logic              stop;
    logic              crcReq;
    logic              crcDone;
    logic              senseHold;
    logic              held;
    logic [15:0]       lowLim;
    logic [47:0]       calPass;
    logic [7:0]        rsp [0:95];
    int                bad_count;
    int                checked;

    always #12.5 clock = ~clock;

    tks_responder #(.SETUP_LEN(16), .GAP_CYCLES(50), .SYNC_CYCLES(200))
    tks_responder_i (
        .clock(clock), .sys_rst(sys_rst), .rxIn(rxIn), .txReady(txReady),
        .txValid(txValid), .txByte(txByte), .keys(keys),
        .keyCalEnd(keyCalEnd), .keyCalPass(calPass),
        .keySignals(keySignals), .keyRefs(keyRefs),
        .lowSignalLimit(lowLim), .xLineFault(xLineFault),
        .yLineFault(yLineFault), .setupsCorrupt(1'h1), .syncPin(syncPin),
        .setupRdAddr(rdAddr), .setupRdData({4'hA, rdAddr}),
        .setupCrc(16'hC3D2), .storeCrcReq(crcReq), .storeCrcDone(crcDone),
        .storeCrcValue(16'h5E71), .codeByte(codeByte),
        .codeWord(codeWord), .senseHold(senseHold), .slowScan(slowScan),
        .linkFail(linkFail)
    );

    tks_host_model tks_host_model_i (
        .clock(clock), .slow(slow), .stop(stop), .txReady(txReady)
    );

    // Store CRC engine stand-in: answers each request half a cycle later, on the falling edge
    always @(negedge clock) crcDone <= crcReq;

    task automatic complete_run();
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [7:0] crc8(input logic [7:0] s,
                                        input logic [7:0] d);
        logic [7:0] c;
        c = s ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
        end
        return c;
    endfunction : crc8

    // Sends one command, takes n bytes plus an optional CRC byte
    task automatic run(input logic [7:0] c, input int n, input bit crc);
        int         k;
        int         t;
        logic [7:0] r;
        k = 0;
        t = 0;
        r = crc8(8'h00, c);
        @(negedge clock) rxIn = {1'h1, 1'h0, c};
        @(negedge clock) rxIn = '0;
        while (k < n + crc) begin
            @(negedge clock);
            if (txValid === 1'h1 && txReady === 1'h1) begin
                if (k == 0) held = senseHold;
                rsp[k] = txByte;
                k++;
            end
            if (++t > 3000) begin
                bad_count++;
                complete_run();
            end
        end
        for (int i = 0; i < n; i++) r = crc8(r, rsp[i]);
        if (crc) chk("crc", r, rsp[n]);
        @(negedge clock);
    endtask : run

    initial begin
        clock = 0; sys_rst = 1; rxIn = '0; keys = '0; keyCalEnd = '0;
        keys.enabled = '1; keySignals = '0; keyRefs = '0; slow = 0;
        stop = 0; lowLim = '0; calPass = '0; held = 0;
        xLineFault = 8'h00; yLineFault = 0; syncPin = 0;
        codeByte = 8'hA5; codeWord = 24'h123456;
        bad_count = 0; checked = 0;
        repeat (20) @(negedge clock);
        sys_rst = 0;
        repeat (250) @(negedge clock);
        run(tks_pkg::CMD_STATUS, 1, 1);
        chk("status", 8'h18, rsp[0]);
        chk("slowScan", 8'h01, {7'h00, slowScan});
        lowLim = 16'h0001;
        run(tks_pkg::CMD_ERRMAP, 6, 1);
        chk("errmap", 8'hFF, rsp[5]);
        lowLim = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            @(negedge clock) keyCalEnd[7] = 1;
            @(negedge clock) keyCalEnd[7] = 0;
            if (i == 3) begin
                run(tks_pkg::CMD_STATUS, 1, 1);
                chk("status", 8'h18, rsp[0]);
            end
        end
        run(tks_pkg::CMD_STATUS, 1, 1);
        chk("status", 8'h1C, rsp[0]);
        calPass[7] = 1;
        @(negedge clock) keyCalEnd[7] = 1;
        @(negedge clock) keyCalEnd[7] = 0;
        run(tks_pkg::CMD_FIRST, 1, 1);
        chk("first", 8'h7F, rsp[0]);
        keys.detect[3] = 1;
        keys.detect[40] = 1;
        run(tks_pkg::CMD_FIRST, 1, 1);
        chk("first", 8'hC3, rsp[0]);
        run(tks_pkg::CMD_DETECT, 6, 1);
        for (int i = 0; i < 6; i++) begin
            chk("map", i == 0 ? 8'h08 : i == 5 ? 8'h01 : 8'h00, rsp[i]);
        end
        keys.calib[9] = 1;
        run(tks_pkg::CMD_ERRMAP, 6, 1);
        chk("errmap", 8'h02, rsp[1]);
        keys.calib[9] = 0;
        run(tks_pkg::CMD_ERRMAP, 6, 1);
        chk("errmap", 8'h00, rsp[1]);
        xLineFault = 8'h05;
        run(tks_pkg::CMD_LINE, 1, 1);
        chk("line", 8'h05, rsp[0]);
        yLineFault = 1;
        run(tks_pkg::CMD_LINE, 1, 1);
        chk("line", 8'hFF, rsp[0]);
        run(tks_pkg::CMD_CODE1, 1, 1);
        chk("code", 8'hA5, rsp[0]);
        run(tks_pkg::CMD_CODE3, 3, 1);
        chk("word0", 8'h56, rsp[0]);
        chk("word2", 8'h12, rsp[2]);
        @(negedge clock) rxIn = {1'h0, 1'h1, 8'h00};
        @(negedge clock) rxIn = '0;
        run(tks_pkg::CMD_STATUS, 1, 1);
        chk("status", 8'h79, rsp[0]);
        @(negedge clock) rxIn = {1'h1, 1'h0, 8'h12};
        @(negedge clock) rxIn = '0;
        run(tks_pkg::CMD_LAST, 1, 0);
        chk("last", 8'hED, rsp[0]);
        run(tks_pkg::CMD_LAST, 1, 0);
        chk("last", 8'hF0, rsp[0]);
        chk("linkFail", 8'h00, {7'h00, linkFail});
        stop = 1;
        @(negedge clock) rxIn = {1'h1, 1'h0, tks_pkg::CMD_STATUS};
        @(negedge clock) rxIn = '0;
        repeat (60) @(negedge clock);
        chk("txValid", 8'h00, {7'h00, txValid});
        stop = 0;
        run(tks_pkg::CMD_LAST, 1, 0);
        chk("last", 8'hFA, rsp[0]);
        slow = 1;
        keyRefs[15:0] = 16'h0200;
        keySignals[31:16] = 16'h0010;
        keyRefs[47:32] = 16'h0050;
        keySignals[47:32] = 16'h0010;
        run(tks_pkg::CMD_DELTA, 48, 0);
        chk("delta0", 8'hFF, rsp[0]);
        chk("delta1", 8'h00, rsp[1]);
        chk("delta2", 8'h40, rsp[2]);
        run(tks_pkg::CMD_REFS, 96, 0);
        chk("refHi", 8'h02, rsp[1]);
        run(tks_pkg::CMD_SIGNAL, 96, 0);
        chk("sigLo", 8'h10, rsp[2]);
        run(tks_pkg::CMD_DUMP, 18, 0);
        chk("dump0", 8'hA0, rsp[0]);
        chk("dumpF", 8'hAF, rsp[15]);
        chk("dumpCrc", 8'hD2, rsp[16]);
        chk("dumpCrcHi", 8'hC3, rsp[17]);
        chk("senseHold", 8'h01, {7'h00, held});
        run(tks_pkg::CMD_EECRC, 2, 0);
        chk("eeCrc", 8'h71, rsp[0]);
        chk("eeCrcHi", 8'h5E, rsp[1]);
        chk("senseHold", 8'h00, {7'h00, held});
        syncPin = 1;
        repeat (4) @(negedge clock);
        run(tks_pkg::CMD_STATUS, 1, 1);
        chk("status", 8'h31, rsp[0]);
        chk("slowScan", 8'h00, {7'h00, slowScan});
        complete_run();
    end
endmodule : tks_responder_test
